//--- core/cfg_defines.vh
// Purpose: constants for the configuration word decoder and prescaler
// Assumes: 25 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   byte addresses are four times the printed word index
`ifndef CFG_DEFINES_VH
`define CFG_DEFINES_VH
// register map (config word index as printed, byte address = 4 x index)
`define CFG_WORD_INDEX       14'h2007
`define CFG_WORD_ADDR        16'h801C
`define CFG_SPACE_LO         14'h2000
`define CFG_SPACE_HI         14'h3FFF
`define TIMER_SETUP_ADDR     16'h0000
`define TIMER_COUNT_ADDR     16'h0004
`define CONTROL_ADDR         16'h0008
`define STATUS_ADDR          16'h000C
`define PROG_DATA_ADDR       16'h0010
// config word fields
`define CP_HI_MSB            13
`define CP_HI_LSB            8
`define POWERUP_DELAY_ENABLE_N_BIT            4
`define WATCHDOG_ENABLE_BIT_BIT             3
`define FOSC_MSB             2
`define CFG_ERASED           14'h3FFF
// oscillator modes
`define OSC_EXTERNAL_RC_OSC_MODE_CLK        3'h7
`define OSC_EXTERNAL_RC_OSC_MODE_IO         3'h6
`define OSC_INTERNAL_RC_OSC_MODE_CLK        3'h5
`define OSC_INTERNAL_RC_OSC_MODE_IO         3'h4
`define OSC_INVALID          3'h3
`define OSC_HS               3'h2
`define OSC_XT               3'h1
`define OSC_LP               3'h0
// protection limits
`define PROT_400             11'h400
`define PROT_200             11'h200
`define PROT_TOP             11'h7FE
// timer setup fields and reset value
`define SETUP_RESET          8'hFF
`define PSA_BIT              3
// timing
`define CLK_HZ               25000000
`define POWERUP_DELAY_TIMER_MS              72
`define POWERUP_DELAY_TIMER_CYCLES          (`CLK_HZ / 1000 * `POWERUP_DELAY_TIMER_MS)
`define OST_CYCLES           1024
`define WDT_TICK_CYCLES      450
`define INTERNAL_RC_OSC_MODE_HZ             4000000
`endif

//--- core/config_word_decode_and_prescaler.v
// Purpose: decodes the configuration word and runs reset hold, sleep wake,
//          shared prescaler, timer and watchdog.
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only.
// Notes:   clock enable low freezes every state element.
//
// Overview of operation
// - config word at 2007h, programmed bit reads zero
// - config space reachable only in programming mode
// - protect pairs: none, 400h-7FEh, 200h-7FEh, all
// - powerup delay enable low turns timer on
// - watchdog enable bit high turns watchdog on
// - three-bit oscillator select decoded to eight modes
// - powerup delay of 72 ms never holds reset: rst_b reloads the erased word, enable bit high
// - oscillator startup timer holds reset until stable
// - watchdog off only by config, own oscillator
// - sleep ends on reset, watchdog or interrupt
// - one prescaler shared exclusively, other side unscaled
// - owner bit and ratio field in setup bits 3:0
// - timer count write clears prescaler when timer owns
// - watchdog clear clears watchdog, and prescaler when watchdog owns
// - prescaler count never read or loaded directly
// - internal RC modes run nominal 4 MHz
// - crystal modes also accept external clock input
//
// Our own choice: the AHB-Lite interface to the registers.
module config_word_decode_and_prescaler
(
    // clock, reset, enable
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        clkEn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [15:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // pins and core events
    input  wire        progModePin,
    input  wire        extWakePin,
    input  wire        wdtOscTick,
    input  wire        timerClkTick,
    input  wire        wdtClearInstr,
    input  wire        sleepInstr,
    input  wire        irqPending,
    input  wire [10:0] fetchAddr,
    // decoded outputs
    output reg         coreReset,
    output reg         sleeping,
    output reg         wdtReset,
    output reg         fetchProtected,
    output reg  [2:0]  oscMode,
    output reg         clockOutEn,
    output reg         intRcSel,
    output reg         extClkAllowed
);
`include "cfg_defines.vh"

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // prescaler tap select: true when counter just passed 2^n boundary
    function tapHit;
        input [7:0] cnt;
        input [3:0] shift;
        begin
            if (shift == 4'h0)
                tapHit = 1'b1;
            else
                tapHit = (cnt & ((8'h01 << shift) - 8'h01)) == 8'h00;
        end
    endfunction

    // protection decode for a program address
    function isProt;
        input [1:0]  pair;
        input [10:0] addr;
        begin
            case (pair)
                2'b11:   isProt = 1'b0;
                2'b10:   isProt = (addr >= `PROT_400) && (addr <= `PROT_TOP);
                2'b01:   isProt = (addr >= `PROT_200) && (addr <= `PROT_TOP);
                default: isProt = 1'b1;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg [1:0] progSync_q;
    reg [1:0] wakeSync_q;
    reg [1:0] wdtTkSync_q;
    reg [1:0] tmrTkSync_q;
    reg       wdtTkOld_q;
    reg       tmrTkOld_q;
    wire      progMode = progSync_q[1];
    wire      wdtTick  = wdtTkSync_q[1] & ~wdtTkOld_q;
    wire      tmrTick  = tmrTkSync_q[1] & ~tmrTkOld_q;

    // pins pass two flops before any logic reads them
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            progSync_q  <= 2'h0;
            wakeSync_q  <= 2'h0;
            wdtTkSync_q <= 2'h0;
            tmrTkSync_q <= 2'h0;
            wdtTkOld_q  <= 1'b0;
            tmrTkOld_q  <= 1'b0;
        end
        else if (clkEn)
        begin
            progSync_q  <= {progSync_q[0], progModePin};
            wakeSync_q  <= {wakeSync_q[0], extWakePin};
            wdtTkSync_q <= {wdtTkSync_q[0], wdtOscTick};
            tmrTkSync_q <= {tmrTkSync_q[0], timerClkTick};
            wdtTkOld_q  <= wdtTkSync_q[1];
            tmrTkOld_q  <= tmrTkSync_q[1];
        end
    end

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    reg        wrPend_q;
    reg [15:0] wrAddr_q;
    reg [13:0] cfgWord_q;
    reg [7:0]  setup_q;
    reg [7:0]  tmrCount_q;
    reg        softWake_q;
    wire       acc = hsel & hready & htrans[1] & clkEn;
    wire       wrHit = wrPend_q & clkEn;
    wire       tmrWr = wrHit & (wrAddr_q == `TIMER_COUNT_ADDR);
    wire       ownerWdt = setup_q[`PSA_BIT];
    wire [3:0] ratio = {1'b0, setup_q[2:0]};

    // read mux; config space answers only in programming mode
    reg [31:0] rdMux;
    always @*
    begin
        rdMux = 32'h0000_0000;
        case (haddr)
            `TIMER_SETUP_ADDR: rdMux = {24'h0, setup_q};
            `TIMER_COUNT_ADDR: rdMux = {24'h0, tmrCount_q};
            `CONTROL_ADDR:     rdMux = 32'h0000_0000;
            `STATUS_ADDR:      rdMux = {26'h0, progMode, wdtReset, sleeping,
                                        coreReset, fetchProtected, 1'b0};
            `CFG_WORD_ADDR:    rdMux = progMode ? {18'h0, cfgWord_q} : 32'h0;
            default:           rdMux = 32'h0000_0000;
        endcase
    end

    // zero-wait slave: write lands in the data phase
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPend_q  <= 1'b0;
            wrAddr_q  <= 16'h0000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else if (clkEn)
        begin
            wrPend_q <= acc & hwrite;
            if (acc)
                wrAddr_q <= haddr;
            if (acc && !hwrite)
                hrdata <= rdMux;
        end
    end

    // ------------------------------------------------------------
    // software registers; prescaler itself has no address
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfgWord_q  <= `CFG_ERASED; // unprogrammed bits read one
            setup_q    <= `SETUP_RESET;
            softWake_q <= 1'b0;
        end
        else if (clkEn)
        begin
            softWake_q <= 1'b0;
            if (wrHit)
            begin
                case (wrAddr_q)
                    `TIMER_SETUP_ADDR: setup_q <= hwdata[7:0];
                    `CONTROL_ADDR:     softWake_q <= hwdata[0];
                    // programming can only clear bits
                    `CFG_WORD_ADDR:
                        if (progMode)
                            cfgWord_q <= cfgWord_q & hwdata[13:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    wire [1:0] cpPair  = cfgWord_q[`CP_HI_LSB+1:`CP_HI_LSB];
    wire       pwrtOn  = ~cfgWord_q[`POWERUP_DELAY_ENABLE_N_BIT];
    wire       wdtOn   = cfgWord_q[`WATCHDOG_ENABLE_BIT_BIT];   // no run-time disable
    wire [2:0] fosc    = cfgWord_q[`FOSC_MSB:0];
    wire       xtalMode = (fosc == `OSC_LP) || (fosc == `OSC_XT) || (fosc == `OSC_HS);

    // registered oscillator decode outputs
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oscMode        <= `OSC_EXTERNAL_RC_OSC_MODE_CLK;
            clockOutEn     <= 1'b0;
            intRcSel       <= 1'b0;
            extClkAllowed  <= 1'b0;
            fetchProtected <= 1'b0;
        end
        else if (clkEn)
        begin
            oscMode       <= fosc;
            clockOutEn    <= (fosc == `OSC_EXTERNAL_RC_OSC_MODE_CLK) || (fosc == `OSC_INTERNAL_RC_OSC_MODE_CLK);
            intRcSel      <= (fosc == `OSC_INTERNAL_RC_OSC_MODE_CLK) || (fosc == `OSC_INTERNAL_RC_OSC_MODE_IO);
            extClkAllowed <= xtalMode;
            // user fetch never reaches 2000h+ so config space stays hidden
            fetchProtected <= isProt(cpPair, fetchAddr);
        end
    end

    // ------------------------------------------------------------
    // reset hold: powerup delay then oscillator startup
    // ------------------------------------------------------------
    localparam HOLD_POWERUP_DELAY_TIMER = 2'h0;
    localparam HOLD_OST  = 2'h1;
    localparam HOLD_RUN  = 2'h2;
    reg [1:0]  hold_q;
    reg [20:0] holdCnt_q;

    // powerup_delay_timer only on power-up; wdt reset re-enters just the startup wait
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_q    <= HOLD_POWERUP_DELAY_TIMER;
            holdCnt_q <= 21'h0;
            coreReset <= 1'b1;
        end
        else if (clkEn)
        begin
            case (hold_q)
                HOLD_POWERUP_DELAY_TIMER:
                    if (!pwrtOn || holdCnt_q == `POWERUP_DELAY_TIMER_CYCLES - 1)
                    begin
                        hold_q    <= HOLD_OST;
                        holdCnt_q <= 21'h0;
                    end
                    else
                        holdCnt_q <= holdCnt_q + 21'h1;
                HOLD_OST:
                    if (!xtalMode || holdCnt_q == `OST_CYCLES - 1)
                    begin
                        hold_q    <= HOLD_RUN;
                        coreReset <= 1'b0;
                    end
                    else
                        holdCnt_q <= holdCnt_q + 21'h1;
                HOLD_RUN:
                    if (wdtReset)
                    begin
                        hold_q    <= HOLD_OST;
                        holdCnt_q <= 21'h0;
                        coreReset <= 1'b1;
                    end
                default: hold_q <= HOLD_POWERUP_DELAY_TIMER;
            endcase
        end
    end

    // ------------------------------------------------------------
    // shared prescaler, timer and watchdog
    // ------------------------------------------------------------
    reg [7:0] pre_q;
    reg [7:0] wdt_q;
    // tap on the incremented count so a cleared prescaler waits a full period
    wire      tmrStep = ownerWdt ? tmrTick : (tmrTick && tapHit(pre_q + 8'h01, ratio + 4'h1));
    wire      wdtStep = ownerWdt ? (wdtTick && tapHit(pre_q + 8'h01, ratio)) : wdtTick;
    wire      wdtClr  = wdtClearInstr & ~coreReset;

    // one counter, only its owner's tick advances it
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_q      <= 8'h00;
            wdt_q      <= 8'h00;
            tmrCount_q <= 8'h00;
            wdtReset   <= 1'b0;
        end
        else if (clkEn)
        begin
            wdtReset <= 1'b0;
            if ((tmrWr && !ownerWdt) || (wdtClr && ownerWdt))
                pre_q <= 8'h00;
            else if (ownerWdt ? wdtTick : tmrTick)
                pre_q <= pre_q + 8'h01;
            if (tmrWr)
                tmrCount_q <= hwdata[7:0];
            else if (tmrStep && !sleeping)
                tmrCount_q <= tmrCount_q + 8'h01;
            // wdt runs from its own oscillator tick
            if (!wdtOn || wdtClr || coreReset)
                wdt_q <= 8'h00;
            else if (wdtStep)
            begin
                wdt_q <= wdt_q + 8'h01;
                if (wdt_q == 8'hFF)
                    wdtReset <= ~sleeping;
            end
        end
    end

    // ------------------------------------------------------------
    // sleep control
    // ------------------------------------------------------------
    wire wdtWake = wdtOn && wdtStep && (wdt_q == 8'hFF);

    // wake on pin reset request, watchdog expiry or pending interrupt
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            sleeping <= 1'b0;
        else if (clkEn)
        begin
            if (sleeping && (wakeSync_q[1] || wdtWake || irqPending || softWake_q))
                sleeping <= 1'b0;
            else if (sleepInstr && !coreReset)
                sleeping <= 1'b1;
        end
    end
endmodule

//--- sim/config_word_monitor.sv
// Purpose: port checker for the config decoder and prescaler
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached by the bind after the module
module config_word_monitor
(
    // clock and reset
    input logic        sys_clk,
    input logic        rst_b,
    // bus
    input logic        clkEn,
    input logic        hsel,
    input logic        hready,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [31:0] hrdata,
    input logic        hreadyout,
    input logic        hresp,
    // core events and decoded outputs
    input logic        extWakePin,
    input logic        wdtClearInstr,
    input logic        sleepInstr,
    input logic        irqPending,
    input logic        coreReset,
    input logic        sleeping,
    input logic        wdtReset,
    input logic [2:0]  oscMode,
    input logic        clockOutEn,
    input logic        intRcSel,
    input logic        extClkAllowed
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // bus answers
    // ----------------------------------------
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("slave stalled or flagged");
    // read data only moves after a taken read
    property p_hold; !(hsel && hready && htrans[1] && !hwrite && clkEn) |=> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved unasked");
    // ----------------------------------------
    // oscillator decode, held off while in reset
    // ----------------------------------------
    property p_clock_output_pin; !coreReset |-> clockOutEn == (oscMode == 3'h7 || oscMode == 3'h5);
    endproperty
    a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock out decode wrong");
    property p_internal_rc_osc_mode; !coreReset |-> intRcSel == (oscMode[2:1] == 2'h2); endproperty
    a_internal_rc_osc_mode: assert property (p_internal_rc_osc_mode) else $error("internal rc decode wrong");
    property p_extClk; !coreReset |-> extClkAllowed == (oscMode <= 3'h2); endproperty
    a_extClk: assert property (p_extClk) else $error("crystal mode decode wrong");
    // ----------------------------------------
    // watchdog and sleep
    // ----------------------------------------
    property p_wdtPulse; wdtReset |=> !wdtReset; endproperty
    a_wdtPulse: assert property (p_wdtPulse) else $error("watchdog reset too long");
    property p_clear; wdtClearInstr |=> !wdtReset; endproperty
    a_clear: assert property (p_clear) else $error("watchdog fired after clear");
    property p_sleep; sleepInstr && !irqPending && !extWakePin && !coreReset |=> sleeping;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    property p_irqWake; sleeping && irqPending |-> ##[1:3] !sleeping; endproperty
    a_irqWake: assert property (p_irqWake) else $error("no wake on interrupt");
    property p_extWake; sleeping && extWakePin |-> ##[1:4] !sleeping; endproperty
    a_extWake: assert property (p_extWake) else $error("no wake on pin");
endmodule
bind config_word_decode_and_prescaler config_word_monitor u_mon
(
    .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .hsel(hsel), .hready(hready),
    .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .extWakePin(extWakePin), .wdtClearInstr(wdtClearInstr),
    .sleepInstr(sleepInstr), .irqPending(irqPending), .coreReset(coreReset),
    .sleeping(sleeping), .wdtReset(wdtReset), .oscMode(oscMode),
    .clockOutEn(clockOutEn), .intRcSel(intRcSel), .extClkAllowed(extClkAllowed)
);

//--- sim/config_word_decode_and_prescaler_tb.sv
// Purpose: self-checking bench for the config decoder and prescaler
// Assumes: zero wait bus, power-up delay left off, crystal start-up only in the last test
// Notes:   random config words from a fixed xorshift seed
`include "cfg_defines.vh"
module config_word_decode_and_prescaler_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk;
    logic        rst_b;
    logic        hsel;
    logic [15:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        progModePin;
    logic [3:0]  ev;
    logic [1:0]  ticks;
    logic [10:0] fetchAddr;
    logic        coreReset, sleeping, wdtReset, fetchProtected;
    logic        clockOutEn, intRcSel, extClkAllowed, wdtSeen;
    logic [2:0]  oscMode;
    logic [31:0] rd, seed, word;
    logic [1:0]  cp;
    int          errors, tests_run, cycles, n;
    config_word_decode_and_prescaler DUT
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .progModePin(progModePin),
        .extWakePin(ev[3]), .wdtOscTick(ticks[1]), .timerClkTick(ticks[0]),
        .wdtClearInstr(ev[0]), .sleepInstr(ev[1]), .irqPending(ev[2]),
        .fetchAddr(fetchAddr), .coreReset(coreReset), .sleeping(sleeping),
        .wdtReset(wdtReset), .fetchProtected(fetchProtected), .oscMode(oscMode),
        .clockOutEn(clockOutEn), .intRcSel(intRcSel), .extClkAllowed(extClkAllowed)
    );
    // ----------------------------------------
    // clock, timeout and watchdog capture
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // a hung wait ends the run here instead of spinning forever
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (wdtReset === 1'b1) wdtSeen <= 1'b1;
        if (cycles == 60000)
        begin
            errors = errors + 1;
            results();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // protected ranges by pair code, all upper bounds inclusive
    function automatic logic expProt(input logic [1:0] c, input logic [10:0] a);
        case (c)
            2'h3: return 1'b0;
            2'h2: return a >= 11'h400 && a <= 11'h7FE;
            2'h1: return a >= 11'h200 && a <= 11'h7FE;
            default: return 1'b1;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single word transfer, address phase held until ready
    task automatic ahb(input logic [15:0] a, input logic w, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic tick(input logic [1:0] which, input int k);
        repeat (k)
        begin
            ticks <= which;
            repeat (2) @(posedge sys_clk);
            ticks <= 2'h0;
            repeat (2) @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic pulse(input logic [3:0] which);
        ev <= which;
        @(posedge sys_clk);
        ev <= 4'h0;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic doReset();
        rst_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wdtSeen = 1'b0;
    endtask
    task automatic results();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {rst_b, hsel, haddr, htrans, hwrite, hwdata, progModePin} = '0;
        {ev, ticks, fetchAddr, wdtSeen, cycles, errors, tests_run} = '0;
        seed = 32'd97287;
        doReset();
        chk(coreReset, 1'b0);
        ahb(`CFG_WORD_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h0);
        ahb(`TIMER_SETUP_ADDR, 1'b0, 32'h0);
        chk(rd, 32'hFF);
        ahb(16'h0020, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // every oscillator mode with a random protection pair
        for (int m = 0; m < 8; m++)
        begin
            progModePin <= 1'b1;
            doReset();
            cp = rnd();
            word = {18'h0, {3{cp}}, 4'hF, 4'h0} | (rnd() & 32'h8) | m;
            ahb(`CFG_WORD_ADDR, 1'b1, word);
            progModePin <= 1'b0;
            ahb(`CFG_WORD_ADDR, 1'b1, 32'h0);
            progModePin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            ahb(`CFG_WORD_ADDR, 1'b0, 32'h0);
            chk(rd, word);
            chk({oscMode, clockOutEn, intRcSel, extClkAllowed},
                {m[2:0], m == 7 || m == 5, m == 5 || m == 4, m <= 2});
            foreach (word[i])
            begin
                fetchAddr <= (i < 6) ? 11'h1FF + (i[2:0] * 11'h100) : rnd();
                repeat (2) @(posedge sys_clk);
                chk(fetchProtected, expProt(cp, fetchAddr));
            end
        end
        // timer prescale ratios and clearing on count writes
        for (int r = 0; r < 3; r++)
        begin
            ahb(`TIMER_SETUP_ADDR, 1'b1, r);
            ahb(`TIMER_COUNT_ADDR, 1'b1, 32'h0);
            tick(2'h1, 3 << (r + 1));
            ahb(`TIMER_COUNT_ADDR, 1'b0, 32'h0);
            chk(rd, 32'h3);
        end
        // leave the prescaler one tick short of a step, so a missed clear shows
        tick(2'h1, 7);
        ahb(`TIMER_COUNT_ADDR, 1'b1, 32'h10);
        tick(2'h1, 1);
        ahb(`TIMER_COUNT_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h10);
        // watchdog owns the prescaler: timer runs unscaled
        doReset();
        ahb(`TIMER_SETUP_ADDR, 1'b1, 32'h08);
        ahb(`TIMER_COUNT_ADDR, 1'b1, 32'h0);
        tick(2'h1, 2);
        ahb(`TIMER_COUNT_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h2);
        // interrupt, pin and soft wake in turn, the soft wake through the bus
        for (int s = 2; s < 5; s++)
        begin
            pulse(4'h2);
            chk(sleeping, 1'b1);
            if (s < 4) pulse(4'h1 << s);
            else ahb(`CONTROL_ADDR, 1'b1, 32'h1);
            repeat (4) @(posedge sys_clk);
            chk(sleeping, 1'b0);
        end
        // a clear in mid-count keeps the watchdog from firing
        pulse(4'h1);
        tick(2'h2, 200);
        pulse(4'h1);
        tick(2'h2, 200);
        chk(wdtSeen, 1'b0);
        n = 200;
        while (wdtSeen !== 1'b1 && n < 300)
        begin
            tick(2'h2, 1);
            n++;
        end
        chk(n >= 255 && n <= 257, 1'b1);
        // watchdog overflow while asleep wakes instead of resetting
        wdtSeen = 1'b0;
        pulse(4'h3);
        n = 0;
        while (sleeping === 1'b1 && n < 300)
        begin
            tick(2'h2, 1);
            n++;
        end
        chk({n >= 250 && n <= 257, wdtSeen}, 2'h2);
        // watchdog turned off by its configuration bit
        progModePin <= 1'b1;
        doReset();
        ahb(`CFG_WORD_ADDR, 1'b1, 32'h3FF7);
        ahb(`TIMER_SETUP_ADDR, 1'b1, 32'h08);
        tick(2'h2, 300);
        chk(wdtSeen, 1'b0);
        // watchdog reset in a crystal mode waits out the startup timer
        doReset();
        ahb(`CFG_WORD_ADDR, 1'b1, 32'h3FF8);
        ahb(`TIMER_SETUP_ADDR, 1'b1, 32'h08);
        tick(2'h2, 255);
        ticks <= 2'h2;
        while (wdtReset !== 1'b1) @(posedge sys_clk);
        ticks <= 2'h0;
        repeat (1000) @(posedge sys_clk);
        chk(coreReset, 1'b1);
        repeat (30) @(posedge sys_clk);
        chk(coreReset, 1'b0);
        results();
    end
endmodule
